// File: src/girc_pkg.sv
/*
 * Shared constants for the gate input response controller: register map,
 * field positions, reset values, pin indices and timing figures.
 * Assumes a 100 MHz system clock and a classic Wishbone register bus.
 */
package girc_pkg;

    // Clock rate
    localparam int CLK_HZ          = 100_000_000;

    // Timing figures in their own units
    localparam int HALT_TIME_MS    = 200;   // Motor rest before an obstruction reversal
    localparam int BACKOFF_TIME_MS = 1000;  // Short travel after an open obstruction
    localparam int SECOND_TIME_MS  = 1000;  // Auto-close time base

    // Derived cycle counts
    localparam int HALT_CYC    = HALT_TIME_MS * (CLK_HZ / 1000);
    localparam int BACKOFF_CYC = BACKOFF_TIME_MS * (CLK_HZ / 1000);
    localparam int SECOND_CYC  = SECOND_TIME_MS * (CLK_HZ / 1000);

    // Register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ACTIME  = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_IRQSTAT = 8'h0C;
    localparam logic [7:0] REG_IRQCLR  = 8'h10;
    localparam logic [7:0] REG_IRQEN   = 8'h14;

    // Control register fields
    localparam int CTRL_STEP3_BIT = 0;  // 1: open-stop-close, 0: open-close
    localparam int CTRL_ACEN_BIT  = 1;  // Auto-close enable

    // Reset values
    localparam logic [1:0] CTRL_RESET   = 2'h0;
    localparam logic [7:0] ACTIME_RESET = 8'h00;
    localparam logic [3:0] IRQEN_RESET  = 4'h0;

    // Interrupt event bits
    localparam int IRQ_W          = 4;
    localparam int EV_OPENED      = 0;
    localparam int EV_CLOSED      = 1;
    localparam int EV_OBSTRUCTION = 2;
    localparam int EV_LOCKOUT     = 3;

    // Pin vector indices
    localparam int PIN_W        = 13;
    localparam int P_SINGLE     = 0;
    localparam int P_OPEN       = 1;
    localparam int P_CLOSE      = 2;
    localparam int P_STOP       = 3;
    localparam int P_OOBS       = 4;
    localparam int P_COBS       = 5;
    localparam int P_REVERSE    = 6;
    localparam int P_EXITLOOP   = 7;
    localparam int P_EMERGENCY  = 8;
    localparam int P_LOCKRESET  = 9;
    localparam int P_OPENLIMIT  = 10;
    localparam int P_CLOSELIMIT = 11;
    localparam int P_ENTRAP     = 12;

    // Controller states
    typedef enum logic [2:0] {
        ST_STOPPED,
        ST_OPENING,
        ST_CLOSING,
        ST_OPENED,
        ST_HALT,
        ST_BACKOFF,
        ST_OBS_HOLD,
        ST_LOCKOUT
    } girc_state_t;

endpackage : girc_pkg

// File: src/girc_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bus coherence is implied.
 */
module girc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstN,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;

    // Two stages, first read only by second
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_r  <= '0;
            syncOut <= '0;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule : girc_sync

// File: src/girc_top.sv
/*
 * Gate input response controller: reacts to the wired control, safety and
 * loop inputs of a slide gate and drives the open and close motor commands,
 * the alarm and the lockout indicator. Registers over classic Wishbone.
 * Assumes all pin inputs are active-high levels asynchronous to clk.
 */
// Contract
// - Single button steps the programmed cycle
// - Open input drives gate toward open
// - Held open ignores stop, pauses auto-close
// - Station open, close and stop inputs
// - Open obstruction: halt, short reverse, halt
// - Then no auto-close until fresh command
// - Repeat open obstruction after restart locks out
// - Close obstruction: halt, then open fully
// - Obstruction during that reopen locks out
// - Auto-close closes after obstruction clears
// - Reverse input while closing reopens fully
// - Exit loop opens the gate
// - Exit loop holds the gate open
// - Lockout ignores inputs, shows indication
module girc_top
#(
    parameter int HALT_CYCLES    = girc_pkg::HALT_CYC,
    parameter int BACKOFF_CYCLES = girc_pkg::BACKOFF_CYC,
    parameter int SECOND_CYCLES  = girc_pkg::SECOND_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Control and safety pins
    input  wire logic        singleButton,
    input  wire logic        openRequest,
    input  wire logic        closeRequest,
    input  wire logic        stopRequest,
    input  wire logic        openObstruction,
    input  wire logic        closeObstruction,
    input  wire logic        reverseRequest,
    input  wire logic        exitLoop,
    input  wire logic        emergencyAccess,
    input  wire logic        lockoutReset,
    input  wire logic        openLimit,
    input  wire logic        closeLimit,
    input  wire logic        openEntrapment,
    // Drive and indication
    output logic             motorOpen,
    output logic             motorClose,
    output logic             alarm,
    output logic             lockoutIndicator,
    output logic             irq
);
    import girc_pkg::*;

    // Reset release
    logic rstMeta_r, rstN;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstN      <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN      <= rstMeta_r;
        end
    end

    // Pin synchronisation
    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] pinSync;
    logic [PIN_W-1:0] pinPrev_r;
    logic [PIN_W-1:0] pinRise;

    assign pinRaw = {openEntrapment, closeLimit, openLimit, lockoutReset, emergencyAccess,
                     exitLoop, reverseRequest, closeObstruction, openObstruction,
                     stopRequest, closeRequest, openRequest, singleButton};

    girc_sync #(
        .WIDTH (PIN_W)
    ) u_pinSync (
        .clk     (clk),
        .rstN    (rstN),
        .asyncIn (pinRaw),
        .syncOut (pinSync)
    );

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinPrev_r <= '0;
        end else begin
            pinPrev_r <= pinSync;
        end
    end

    assign pinRise = pinSync & ~pinPrev_r;
    // Register state
    logic [1:0]       ctrl_r;
    logic [7:0]       acTime_r;
    logic [IRQ_W-1:0] irqStat_r;
    logic [IRQ_W-1:0] irqEn_r;
    logic             ack_r;
    logic [31:0]      rdData_r;
    // Controller state
    girc_state_t state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] secCnt_r;
    logic [7:0]  acLeft_r;
    logic        haltToOpen_r, haltToOpen_nxt;
    logic        backoffOpen_r, backoffOpen_nxt;
    logic        lastOpen_r, lastOpen_nxt;
    logic        obsRetry_r, obsRetry_nxt;
    logic        cobsReopen_r, cobsReopen_nxt;
    logic        acDisabled_r, acDisabled_nxt;

    // Input decoding
    wire step3      = ctrl_r[CTRL_STEP3_BIT];
    wire acEnable   = ctrl_r[CTRL_ACEN_BIT];
    wire openHeld   = pinSync[P_OPEN];
    wire singleEdge = pinRise[P_SINGLE];
    wire oObs       = pinSync[P_OOBS];
    wire cObs       = pinSync[P_COBS];
    wire atOpen     = pinSync[P_OPENLIMIT];
    wire atClose    = pinSync[P_CLOSELIMIT];
    wire holdOpen   = openHeld | pinSync[P_EXITLOOP] | pinSync[P_EMERGENCY];
    wire levelOpen  = openHeld | pinSync[P_EXITLOOP] | pinSync[P_EMERGENCY];
    wire freshCmd   = singleEdge | pinRise[P_OPEN] | pinRise[P_CLOSE] | pinRise[P_EXITLOOP]
                    | pinRise[P_EMERGENCY];
    wire stopCmd    = (pinSync[P_STOP] | (singleEdge & step3)) & ~openHeld;
    wire closeCmd   = pinRise[P_CLOSE] & ~holdOpen & ~cObs;
    wire acRunning  = acEnable & (acTime_r != 8'h00) & ~acDisabled_r & ~holdOpen & ~cObs;
    wire secTick    = (secCnt_r == 32'(SECOND_CYCLES - 1));
    wire acExpire   = acRunning & (acLeft_r == 8'h00);

    // Next-state logic
    always_comb begin
        state_nxt       = state_r;
        cnt_nxt         = 32'h0000_0000;
        haltToOpen_nxt  = haltToOpen_r;
        backoffOpen_nxt = backoffOpen_r;
        lastOpen_nxt    = lastOpen_r;
        obsRetry_nxt    = obsRetry_r;
        cobsReopen_nxt  = cobsReopen_r;
        acDisabled_nxt  = acDisabled_r;
        case (state_r)
            ST_STOPPED, ST_OPENED, ST_OBS_HOLD: begin
                if (state_r == ST_OBS_HOLD && !freshCmd) begin
                    state_nxt = ST_OBS_HOLD;
                end else if (levelOpen && !(state_r == ST_OPENED)) begin
                    state_nxt      = ST_OPENING;
                    acDisabled_nxt = 1'b0;
                end else if (closeCmd || (singleEdge && !holdOpen && (state_r == ST_OPENED || lastOpen_r))) begin
                    state_nxt      = ST_CLOSING;
                    acDisabled_nxt = 1'b0;
                end else if (singleEdge && state_r != ST_OPENED) begin
                    state_nxt      = ST_OPENING;
                    acDisabled_nxt = 1'b0;
                end else if (state_r == ST_OPENED && acExpire) begin
                    state_nxt = ST_CLOSING;
                end
                if (state_r == ST_OBS_HOLD && freshCmd && state_nxt != ST_OBS_HOLD) begin
                    obsRetry_nxt = 1'b1;
                end
            end
            ST_OPENING: begin
                lastOpen_nxt = 1'b1;
                if (oObs && (obsRetry_r || cobsReopen_r)) begin
                    state_nxt = ST_LOCKOUT;
                end else if (cobsReopen_r && pinSync[P_ENTRAP]) begin
                    state_nxt = ST_LOCKOUT;
                end else if (oObs) begin
                    state_nxt       = ST_HALT;
                    haltToOpen_nxt  = 1'b0;
                    backoffOpen_nxt = 1'b0;
                end else if (atOpen) begin
                    state_nxt      = ST_OPENED;
                    obsRetry_nxt   = 1'b0;
                    cobsReopen_nxt = 1'b0;
                end else if (stopCmd && !cobsReopen_r) begin
                    state_nxt = ST_STOPPED;
                end else if (singleEdge && !step3 && !holdOpen && !cobsReopen_r) begin
                    state_nxt = ST_CLOSING;
                end else if (closeCmd && !cobsReopen_r) begin
                    state_nxt = ST_CLOSING;
                end
            end
            ST_CLOSING: begin
                lastOpen_nxt = 1'b0;
                if (oObs) begin
                    state_nxt       = obsRetry_r ? ST_LOCKOUT : ST_HALT;
                    haltToOpen_nxt  = 1'b0;
                    backoffOpen_nxt = 1'b1;
                end else if (cObs) begin
                    state_nxt      = ST_HALT;
                    haltToOpen_nxt = 1'b1;
                end else if (pinSync[P_REVERSE] || levelOpen) begin
                    state_nxt = ST_OPENING;
                end else if (atClose) begin
                    state_nxt    = ST_STOPPED;
                    obsRetry_nxt = 1'b0;
                end else if (stopCmd) begin
                    state_nxt = ST_STOPPED;
                end else if (singleEdge) begin
                    state_nxt = ST_OPENING;
                end
            end
            ST_HALT: begin
                cnt_nxt = cnt_r + 32'h0000_0001;
                if (cnt_r == 32'(HALT_CYCLES - 1)) begin
                    cnt_nxt = 32'h0000_0000;
                    if (haltToOpen_r) begin
                        state_nxt      = ST_OPENING;
                        cobsReopen_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_BACKOFF;
                    end
                end
            end
            ST_BACKOFF: begin
                cnt_nxt = cnt_r + 32'h0000_0001;
                if (cnt_r == 32'(BACKOFF_CYCLES - 1) || (backoffOpen_r ? atOpen : atClose)) begin
                    cnt_nxt        = 32'h0000_0000;
                    state_nxt      = ST_OBS_HOLD;
                    acDisabled_nxt = 1'b1;
                end
            end
            ST_LOCKOUT: begin
                if (pinRise[P_LOCKRESET]) begin
                    state_nxt      = ST_STOPPED;
                    obsRetry_nxt   = 1'b0;
                    cobsReopen_nxt = 1'b0;
                    acDisabled_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_STOPPED;
            end
        endcase
    end

    // Controller registers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r       <= ST_STOPPED;
            cnt_r         <= 32'h0000_0000;
            haltToOpen_r  <= 1'b0;
            backoffOpen_r <= 1'b0;
            lastOpen_r    <= 1'b0;
            obsRetry_r    <= 1'b0;
            cobsReopen_r  <= 1'b0;
            acDisabled_r  <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            haltToOpen_r  <= haltToOpen_nxt;
            backoffOpen_r <= backoffOpen_nxt;
            lastOpen_r    <= lastOpen_nxt;
            obsRetry_r    <= obsRetry_nxt;
            cobsReopen_r  <= cobsReopen_nxt;
            acDisabled_r  <= acDisabled_nxt;
        end
    end

    // Auto-close countdown, paused while held, reloaded outside the open dwell
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            secCnt_r <= 32'h0000_0000;
            acLeft_r <= ACTIME_RESET;
        end else if (state_r != ST_OPENED || !acRunning) begin
            secCnt_r <= 32'h0000_0000;
            if (state_r != ST_OPENED || cObs) begin
                acLeft_r <= acTime_r;
            end
        end else if (secTick) begin
            secCnt_r <= 32'h0000_0000;
            if (acLeft_r != 8'h00) begin
                acLeft_r <= acLeft_r - 8'h01;
            end
        end else begin
            secCnt_r <= secCnt_r + 32'h0000_0001;
        end
    end

    // Drive and indication outputs
    wire lockNext = (state_nxt == ST_LOCKOUT);
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            motorOpen        <= 1'b0;
            motorClose       <= 1'b0;
            alarm            <= 1'b0;
            lockoutIndicator <= 1'b0;
        end else begin
            motorOpen        <= (state_nxt == ST_OPENING) | (state_nxt == ST_BACKOFF & backoffOpen_nxt);
            motorClose       <= (state_nxt == ST_CLOSING) | (state_nxt == ST_BACKOFF & ~backoffOpen_nxt);
            alarm            <= lockNext;
            lockoutIndicator <= lockNext;
        end
    end

    // Interrupt events
    logic [IRQ_W-1:0] events;
    assign events[EV_OPENED]      = (state_r == ST_OPENING) & (state_nxt == ST_OPENED);
    assign events[EV_CLOSED]      = (state_r == ST_CLOSING) & (state_nxt == ST_STOPPED) & atClose;
    assign events[EV_OBSTRUCTION] = (state_r != ST_HALT) & (state_nxt == ST_HALT);
    assign events[EV_LOCKOUT]     = (state_r != ST_LOCKOUT) & lockNext;

    // Bus decode
    wire        busReq   = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        busWrite = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];  // Lands as ack is taken
    wire [IRQ_W-1:0] irqClr = (busWrite && wb_adr_i == REG_IRQCLR) ? wb_dat_i[IRQ_W-1:0] : '0;
    logic [31:0] rdMux;
    always_comb begin
        case (wb_adr_i)
            REG_CTRL:    rdMux = {30'h0000_0000, ctrl_r};
            REG_ACTIME:  rdMux = {24'h00_0000, acTime_r};
            REG_STATUS:  rdMux = {16'h0000, acLeft_r, 1'b0, state_r, motorClose, motorOpen,
                                  acDisabled_r, lockoutIndicator};
            REG_IRQSTAT: rdMux = {28'h000_0000, irqStat_r};
            REG_IRQEN:   rdMux = {28'h000_0000, irqEn_r};
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    // Bus registers, ack one cycle after the request
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ack_r    <= 1'b0;
            rdData_r <= 32'h0000_0000;
            ctrl_r   <= CTRL_RESET;
            acTime_r <= ACTIME_RESET;
            irqEn_r  <= IRQEN_RESET;
        end else begin
            ack_r    <= busReq;
            rdData_r <= busReq ? rdMux : 32'h0000_0000;
            if (busWrite && wb_adr_i == REG_CTRL) begin
                ctrl_r <= wb_dat_i[1:0];
            end
            if (busWrite && wb_adr_i == REG_ACTIME) begin
                acTime_r <= wb_dat_i[7:0];
            end
            if (busWrite && wb_adr_i == REG_IRQEN) begin
                irqEn_r <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqStat_r <= '0;
            irq       <= 1'b0;
        end else begin
            irqStat_r <= (irqStat_r & ~irqClr) | events;
            irq       <= |(((irqStat_r & ~irqClr) | events) & irqEn_r);
        end
    end
    // Bus outputs straight from their flops
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdData_r;
endmodule : girc_top

// File: test/girc_monitor.sv
/* Checker for the gate controller: motor, lockout and command timing at the
   top ports. Assumes the sim cycle counts are handed on by the bind. */
module girc_monitor #(
    parameter int HALT_CYCLES    = 8,
    parameter int BACKOFF_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins
    input wire logic openRequest,
    input wire logic openObstruction,
    input wire logic closeObstruction,
    input wire logic reverseRequest,
    input wire logic exitLoop,
    input wire logic lockoutReset,
    input wire logic openLimit,
    // Drive and indication
    input wire logic motorOpen,
    input wire logic motorClose,
    input wire logic alarm,
    input wire logic lockoutIndicator
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OPENWIN = HALT_CYCLES + BACKOFF_CYCLES + 16;
    logic [5:0] resetHist_r;

    // Recent history of the lockout reset pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) resetHist_r <= 6'h00;
        else resetHist_r <= {resetHist_r[4:0], lockoutReset};
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_alarm_lock: assert property (alarm == lockoutIndicator)
        else $error("alarm and lockout indication differ");
    chk_lock_idle: assert property (lockoutIndicator |-> !motorOpen && !motorClose)
        else $error("motor driven in lockout");
    chk_motor_excl: assert property (!(motorOpen && motorClose))
        else $error("both motor directions driven");
    chk_unlock_cause: assert property ($fell(lockoutIndicator) |-> |resetHist_r)
        else $error("lockout left without reset input");
    chk_obs_halt: assert property (!openObstruction && (motorOpen || motorClose) ##1
        openObstruction [*4] |=> !motorOpen && !motorClose)
        else $error("open obstruction did not halt motor");
    chk_cobs_reopen: assert property (motorClose && !closeObstruction ##1 closeObstruction [*4]
        |=> !motorClose ##[1:OPENWIN] motorOpen)
        else $error("close obstruction did not reopen");
    chk_rev_open: assert property ($rose(reverseRequest) && motorClose ##1 reverseRequest [*3]
        |-> ##[1:OPENWIN] motorOpen)
        else $error("reverse input did not reopen");
    chk_exit_hold: assert property (exitLoop [*5] |-> !motorClose)
        else $error("gate closing while exit loop held");
    chk_open_cmd: assert property ($rose(openRequest) && !lockoutIndicator ##1 (openRequest && !openLimit
        && !openObstruction && !closeObstruction && !lockoutIndicator) [*4] |-> ##[0:OPENWIN]
        (motorOpen || openLimit))
        else $error("open input did not open gate");
endmodule : girc_monitor

bind girc_top girc_monitor #(.HALT_CYCLES(HALT_CYCLES), .BACKOFF_CYCLES(BACKOFF_CYCLES)) u_mon (
    .clk(clk), .resetn(resetn), .openRequest(openRequest), .openObstruction(openObstruction),
    .closeObstruction(closeObstruction), .reverseRequest(reverseRequest), .exitLoop(exitLoop),
    .lockoutReset(lockoutReset), .openLimit(openLimit), .motorOpen(motorOpen),
    .motorClose(motorClose), .alarm(alarm), .lockoutIndicator(lockoutIndicator));

// File: test/girc_gate_model.sv
/* Gate and limit switch model: one step of travel per cycle of drive.
   Assumes the gate starts at its closed end. */
module girc_gate_model #(
    parameter int TRAVEL = 40
) (
    // Clock
    input wire logic clk,
    // Motor drive
    input wire logic motorOpen,
    input wire logic motorClose,
    // Limit switches
    output logic     openLimit,
    output logic     closeLimit
);
    timeunit 1ns;
    timeprecision 1ns;
    int pos = 0;

    // Travel stops at either end
    always @(posedge clk) begin
        if (motorOpen && pos < TRAVEL) pos <= pos + 1;
        else if (motorClose && pos > 0) pos <= pos - 1;
    end

    // Switches close at the travel ends
    assign openLimit  = (pos == TRAVEL);
    assign closeLimit = (pos == 0);
endmodule : girc_gate_model

// File: test/tb.sv
/* Self-checking bench for the gate controller: Wishbone registers, pin
   scenarios and random register traffic. Assumes the gate model of test/. */
module tb;
    import girc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, cyc, stb, we, ack, motorOpen, motorClose, alarm, lockoutIndicator, irq;
    logic openLimit, closeLimit;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q, v;
    logic [PIN_W-1:0] pins;
    int errors = 0, nTests = 0, cycles = 0, seed;

    girc_top #(.HALT_CYCLES(8), .BACKOFF_CYCLES(16), .SECOND_CYCLES(10)) u_dut (
        .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .singleButton(pins[P_SINGLE]), .openRequest(pins[P_OPEN]), .closeRequest(pins[P_CLOSE]),
        .stopRequest(pins[P_STOP]), .openObstruction(pins[P_OOBS]), .closeObstruction(pins[P_COBS]),
        .reverseRequest(pins[P_REVERSE]), .exitLoop(pins[P_EXITLOOP]),
        .emergencyAccess(pins[P_EMERGENCY]), .lockoutReset(pins[P_LOCKRESET]), .openLimit(openLimit),
        .closeLimit(closeLimit), .openEntrapment(pins[P_ENTRAP]), .motorOpen(motorOpen),
        .motorClose(motorClose), .alarm(alarm), .lockoutIndicator(lockoutIndicator), .irq(irq));
    girc_gate_model u_gate (.clk(clk), .motorOpen(motorOpen), .motorClose(motorClose),
        .openLimit(openLimit), .closeLimit(closeLimit));

    // Clock and hang guard
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    task end_sim;
        $display("Checks %0d, mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Classic Wishbone cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task press(input int i);
        @(posedge clk);
        pins[i] <= 1'b1;
        idle(5);
        pins[i] <= 1'b0;
        idle(4);
    endtask : press
    // Wait for a motor pattern, bounded
    task waitm(input logic [1:0] m);
        for (int n = 0; n < 300 && {motorOpen, motorClose} !== m; n++) @(posedge clk);
        chk({motorOpen, motorClose}, m);
    endtask : waitm

    initial begin
        resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0; adr = 8'h00; wdat = 32'h0;
        pins = '0; seed = 7181;
        idle(10);
        resetn <= 1'b1;
        idle(4);
        wb(0, REG_CTRL, 0); chk(q, 32'h0);
        wb(0, 8'h20, 0); chk(q, 32'h0);
        wb(1, REG_IRQEN, 32'h1);
        press(P_OPEN); waitm(2'b10); waitm(2'b00); chk(openLimit, 1);
        idle(3); chk(irq, 1);
        wb(1, REG_IRQEN, 32'h0); idle(3); chk(irq, 0);
        wb(1, REG_IRQEN, 32'h1); wb(1, REG_IRQCLR, 32'h1); idle(3); chk(irq, 0);
        $display("Done open and interrupt");
        press(P_CLOSE); waitm(2'b01); press(P_STOP); waitm(2'b00);
        press(P_CLOSE); waitm(2'b01); waitm(2'b00); chk(closeLimit, 1);
        press(P_SINGLE); waitm(2'b10); press(P_SINGLE); waitm(2'b01); waitm(2'b00);
        wb(1, REG_CTRL, 32'h1);
        press(P_SINGLE); waitm(2'b10); press(P_SINGLE); waitm(2'b00);
        press(P_SINGLE); waitm(2'b01); waitm(2'b00);
        $display("Done buttons");
        wb(1, REG_CTRL, 32'h2); wb(1, REG_ACTIME, 32'h2);
        press(P_SINGLE); waitm(2'b10); waitm(2'b01);
        pins[P_COBS] <= 1'b1; waitm(2'b10);
        pins[P_COBS] <= 1'b0; waitm(2'b00); waitm(2'b01);
        press(P_REVERSE); waitm(2'b10); waitm(2'b00);
        pins[P_EXITLOOP] <= 1'b1; idle(30); press(P_SINGLE); idle(30); chk(motorClose, 0);
        pins[P_EXITLOOP] <= 1'b0; waitm(2'b01); waitm(2'b00);
        pins[P_OPEN] <= 1'b1; waitm(2'b10); press(P_STOP); chk(motorOpen, 1);
        waitm(2'b00); idle(60); chk(motorClose, 0);
        pins[P_OPEN] <= 1'b0; waitm(2'b01);
        wb(1, REG_CTRL, 32'h0); waitm(2'b00);
        press(P_EMERGENCY); waitm(2'b10); waitm(2'b00);
        press(P_CLOSE); waitm(2'b00); press(P_EXITLOOP); waitm(2'b10); waitm(2'b00);
        $display("Done safety inputs");
        press(P_CLOSE); idle(15); press(P_OOBS); waitm(2'b10); waitm(2'b00);
        wb(0, REG_STATUS, 0); chk(q[1], 1);
        wb(1, REG_CTRL, 32'h2); idle(60); chk({motorOpen, motorClose}, 0);
        press(P_CLOSE); press(P_OOBS); idle(3); chk(alarm, 1);
        press(P_OPEN); idle(20); chk({motorOpen, motorClose, lockoutIndicator}, 1);
        press(P_LOCKRESET); chk(alarm, 0);
        press(P_CLOSE); pins[P_COBS] <= 1'b1; waitm(2'b10); press(P_OOBS); chk(alarm, 1);
        pins[P_COBS] <= 1'b0; press(P_LOCKRESET); chk(lockoutIndicator, 0);
        press(P_CLOSE); pins[P_COBS] <= 1'b1; waitm(2'b10); press(P_ENTRAP); chk(alarm, 1);
        pins[P_COBS] <= 1'b0; press(P_LOCKRESET); chk(alarm, 0);
        $display("Done lockout");
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            wb(1, REG_ACTIME, v); wb(0, REG_ACTIME, 0); chk(q, {24'h0, v[7:0]});
            press(P_SINGLE); idle(int'(v[13:8])); chk(lockoutIndicator, 0);
        end
        $display("Done random");
        end_sim();
    end
endmodule : tb
